// *** dtc_pkg.sv ***
// Shared constants, types and bus map of the dual timer/counter pair
// Summary of operation
// - Modes 0 and 1: low byte carry advances high byte; high sets flag
// - Run bit enables counting, never clears counts
// - Timer source advances once per six clocks
// - Counter source counts sampled high-then-low transitions
// - Gate set adds external pin to run control
// - Roll-over to zero sets overflow flag
// - Mode 0 is 5-bit prescaler plus 8-bit
// - Mode 1 is full 16-bit cascade counter
// - Mode 2 reloads low byte from high byte
// - Timer 0 mode 3 splits into two timers
// - Timer 1 mode 3 halts and holds count
// - Fixed mode and control bit positions per timer
// - Overflow flag cleared when interrupt is vectored
// - Interrupt needs timer and global enables set
// - Gated timer counts only while pin high
// - Mode field 00,01,10,11 selects modes 0-3
package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_MODE_13BIT,
    DTC_MODE_16BIT,
    DTC_MODE_RELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_type;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic ovf;
  } dtc_cnt_type;

  localparam int PER_CYCLE_CLKS = 6;
  localparam logic [4:0] PRESCALE_MAX = 5'h1F;

  // Byte offsets on the register bus
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_MODE = 5'h04;
  localparam logic [4:0] OFS_T0_LO = 5'h08;
  localparam logic [4:0] OFS_T0_HI = 5'h0C;
  localparam logic [4:0] OFS_T1_LO = 5'h10;
  localparam logic [4:0] OFS_T1_HI = 5'h14;
  localparam logic [4:0] OFS_IRQ_EN = 5'h18;

  // Control register bit positions
  localparam int CTRL_RUN_T0 = 4;
  localparam int CTRL_OVF_T0 = 5;
  localparam int CTRL_RUN_T1 = 6;
  localparam int CTRL_OVF_T1 = 7;

  // Mode register: timer 0 in [3:0], timer 1 in [7:4]
  localparam int MODE_T1_BASE = 4;
  localparam int MODE_GATE_POS = 3;
  localparam int MODE_SRC_POS = 2;

  // Interrupt enable register bit positions
  localparam int IEN_T0 = 0;
  localparam int IEN_T1 = 1;
  localparam int IEN_GLOBAL = 7;

  localparam logic [7:0] RST_BYTE = 8'h00;

endpackage

// *** dtc_tick_gen.sv ***
// Peripheral cycle tick: one pulse every six core clocks
`timescale 1ns/1ps
module dtc_tick_gen (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  output logic o_tick
);
  logic [2:0] div_r;
  logic [2:0] div_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    div_nxt = div_r + 3'h1;
    if (div_r == 3'(dtc_pkg::PER_CYCLE_CLKS - 1)) begin
      div_nxt = 3'h0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r <= 3'h0;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign o_tick = tick_r;

  chk_tick_spacing: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    tick_r |=> !tick_r [*5] ##1 tick_r) else $error("Tick spacing is not six clocks");
endmodule

// *** dtc_pin_cond.sv ***
// Pin synchroniser and falling-edge sampler for one timer
`timescale 1ns/1ps
module dtc_pin_cond (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_count_pin,
  input wire logic i_gate_pin,
  output logic o_fall,
  output logic o_gate_lvl
);
  logic [1:0] cnt_sync_r;
  logic [1:0] gate_sync_r;
  logic sample_r;
  logic sample_nxt;
  logic fall_r;
  logic fall_nxt;

  always_comb begin
    sample_nxt = sample_r;
    fall_nxt = 1'b0;
    // Sampled once per peripheral cycle; a shorter pulse may be missed
    if (i_tick) begin
      sample_nxt = cnt_sync_r[1];
      fall_nxt = sample_r & ~cnt_sync_r[1];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_sync_r <= 2'h0;
      gate_sync_r <= 2'h0;
      sample_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      cnt_sync_r <= {cnt_sync_r[0], i_count_pin};
      gate_sync_r <= {gate_sync_r[0], i_gate_pin};
      sample_r <= sample_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign o_fall = fall_r;
  assign o_gate_lvl = gate_sync_r[1];

  chk_fall_detect: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_tick && sample_r && !cnt_sync_r[1]) |=> fall_r) else $error("Falling edge missed");
  chk_fall_cause: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    fall_r |-> $past(i_tick) && !sample_r) else $error("Spurious count event");
  cov_fall: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) fall_r);
endmodule

// *** dtc_timer_pair.sv ***
// Dual timer/counter top with Avalon-MM register slave
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module dtc_timer_pair (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_count_pin_t0,
  input wire logic i_count_pin_t1,
  input wire logic i_ext_gate_pin_a,
  input wire logic i_ext_gate_pin_b,
  input wire logic i_vec_ack_t0,
  input wire logic i_vec_ack_t1,
  output logic o_irq_t0,
  output logic o_irq_t1
);
  logic tick;
  logic [1:0] fall;
  logic [1:0] gate_lvl;

  logic [7:0] cnt_lo_r [2];
  logic [7:0] cnt_hi_r [2];
  logic [7:0] cnt_lo_nxt [2];
  logic [7:0] cnt_hi_nxt [2];
  logic [1:0] run_bit_r;
  logic [1:0] run_bit_nxt;
  logic [1:0] overflow_flag_r;
  logic [1:0] overflow_flag_nxt;
  logic [7:0] timer_mode_reg_r;
  logic [7:0] timer_mode_reg_nxt;
  logic [2:0] irq_enable_reg_r;
  logic [2:0] irq_enable_reg_nxt;
  logic wait_r;
  logic wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] irq_r;
  logic [1:0] irq_nxt;

  dtc_pkg::dtc_mode_type mode [2];
  logic [1:0] gate_bit;
  logic [1:0] src_sel;
  logic [1:0] inc;
  logic [1:0] ovf_evt;
  logic hi0_inc;
  logic split0;
  logic req;
  logic wr_take;
  dtc_pkg::dtc_cnt_type step [2];

  dtc_tick_gen u_tick (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .o_tick(tick)
  );

  dtc_pin_cond u_cond0 (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_tick(tick),
    .i_count_pin(i_count_pin_t0),
    .i_gate_pin(i_ext_gate_pin_a),
    .o_fall(fall[0]),
    .o_gate_lvl(gate_lvl[0])
  );

  dtc_pin_cond u_cond1 (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_tick(tick),
    .i_count_pin(i_count_pin_t1),
    .i_gate_pin(i_ext_gate_pin_b),
    .o_fall(fall[1]),
    .o_gate_lvl(gate_lvl[1])
  );

  // One increment of a timer in its mode; the caller decides whether it applies
  function automatic dtc_pkg::dtc_cnt_type dtc_step(input dtc_pkg::dtc_mode_type m,
      input logic [7:0] lo, input logic [7:0] hi);
    dtc_pkg::dtc_cnt_type r;
    r.lo = lo + 8'h01;
    r.hi = hi;
    r.ovf = 1'b0;
    unique case (m)
      dtc_pkg::DTC_MODE_13BIT: begin
        // Upper three low-byte bits are left untouched
        r.lo = {lo[7:5], lo[4:0] + 5'h01};
        if (lo[4:0] == dtc_pkg::PRESCALE_MAX) begin
          r.hi = hi + 8'h01;
          r.ovf = (hi == 8'hFF);
        end
      end
      dtc_pkg::DTC_MODE_16BIT: begin
        if (lo == 8'hFF) begin
          r.hi = hi + 8'h01;
          r.ovf = (hi == 8'hFF);
        end
      end
      dtc_pkg::DTC_MODE_RELOAD: begin
        if (lo == 8'hFF) begin
          r.lo = hi;
          r.ovf = 1'b1;
        end
      end
      dtc_pkg::DTC_MODE_SPLIT: begin
        r.ovf = (lo == 8'hFF);
      end
    endcase
    return r;
  endfunction

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      mode[i] = dtc_pkg::dtc_mode_type'(timer_mode_reg_r[4*i +: 2]);
      gate_bit[i] = timer_mode_reg_r[4*i + dtc_pkg::MODE_GATE_POS];
      src_sel[i] = timer_mode_reg_r[4*i + dtc_pkg::MODE_SRC_POS];
      step[i] = dtc_step(mode[i], cnt_lo_r[i], cnt_hi_r[i]);
    end
  end

  assign split0 = (mode[0] == dtc_pkg::DTC_MODE_SPLIT);
  // Run bit only enables the event; it never touches the count bytes
  assign inc[0] = (src_sel[0] ? fall[0] : tick) & run_bit_r[0]
    & (~gate_bit[0] | gate_lvl[0]);
  // With timer 0 split, timer 1 loses its run bit and runs until halted by mode 3
  assign inc[1] = (src_sel[1] ? fall[1] : tick) & (split0 | run_bit_r[1])
    & (~gate_bit[1] | gate_lvl[1]) & (mode[1] != dtc_pkg::DTC_MODE_SPLIT);
  assign hi0_inc = split0 & tick & run_bit_r[1];
  assign ovf_evt[0] = inc[0] & step[0].ovf;
  assign ovf_evt[1] = (inc[1] & step[1].ovf & ~split0) | (hi0_inc & cnt_hi_r[0] == 8'hFF);

  assign req = i_avs_read | i_avs_write;
  assign wr_take = i_avs_write & ~wait_r & i_avs_byteenable[0];

  // Counting, then bus writes on top, then flag sets that win over clears
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cnt_lo_nxt[i] = inc[i] ? step[i].lo : cnt_lo_r[i];
      cnt_hi_nxt[i] = inc[i] ? step[i].hi : cnt_hi_r[i];
    end
    if (hi0_inc) begin
      cnt_hi_nxt[0] = cnt_hi_r[0] + 8'h01;
    end
    run_bit_nxt = run_bit_r;
    overflow_flag_nxt = overflow_flag_r & ~{i_vec_ack_t1, i_vec_ack_t0};
    timer_mode_reg_nxt = timer_mode_reg_r;
    irq_enable_reg_nxt = irq_enable_reg_r;
    // Preset while running is software's hazard; the bus write simply wins
    if (wr_take) begin
      unique case (i_avs_address)
        dtc_pkg::OFS_CTRL: begin
          run_bit_nxt = {i_avs_writedata[dtc_pkg::CTRL_RUN_T1],
            i_avs_writedata[dtc_pkg::CTRL_RUN_T0]};
          overflow_flag_nxt = {i_avs_writedata[dtc_pkg::CTRL_OVF_T1],
            i_avs_writedata[dtc_pkg::CTRL_OVF_T0]};
        end
        dtc_pkg::OFS_MODE: timer_mode_reg_nxt = i_avs_writedata[7:0];
        dtc_pkg::OFS_T0_LO: cnt_lo_nxt[0] = i_avs_writedata[7:0];
        dtc_pkg::OFS_T0_HI: cnt_hi_nxt[0] = i_avs_writedata[7:0];
        dtc_pkg::OFS_T1_LO: cnt_lo_nxt[1] = i_avs_writedata[7:0];
        dtc_pkg::OFS_T1_HI: cnt_hi_nxt[1] = i_avs_writedata[7:0];
        dtc_pkg::OFS_IRQ_EN: irq_enable_reg_nxt = {i_avs_writedata[dtc_pkg::IEN_GLOBAL],
          i_avs_writedata[dtc_pkg::IEN_T1], i_avs_writedata[dtc_pkg::IEN_T0]};
        default: begin
        end
      endcase
    end
    overflow_flag_nxt = overflow_flag_nxt | ovf_evt;
    for (int i = 0; i < 2; i++) begin
      irq_nxt[i] = overflow_flag_r[i] & irq_enable_reg_r[i] & irq_enable_reg_r[2];
    end
  end

  // Bus: one wait cycle, read data captured while waitrequest is high
  always_comb begin
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if (req && wait_r) begin
      wait_nxt = 1'b0;
      rdata_nxt = 32'h0000_0000;
      unique case (i_avs_address)
        dtc_pkg::OFS_CTRL: begin
          rdata_nxt[dtc_pkg::CTRL_RUN_T0] = run_bit_r[0];
          rdata_nxt[dtc_pkg::CTRL_OVF_T0] = overflow_flag_r[0];
          rdata_nxt[dtc_pkg::CTRL_RUN_T1] = run_bit_r[1];
          rdata_nxt[dtc_pkg::CTRL_OVF_T1] = overflow_flag_r[1];
        end
        dtc_pkg::OFS_MODE: rdata_nxt[7:0] = timer_mode_reg_r;
        dtc_pkg::OFS_T0_LO: rdata_nxt[7:0] = cnt_lo_r[0];
        dtc_pkg::OFS_T0_HI: rdata_nxt[7:0] = cnt_hi_r[0];
        dtc_pkg::OFS_T1_LO: rdata_nxt[7:0] = cnt_lo_r[1];
        dtc_pkg::OFS_T1_HI: rdata_nxt[7:0] = cnt_hi_r[1];
        dtc_pkg::OFS_IRQ_EN: begin
          rdata_nxt[dtc_pkg::IEN_T0] = irq_enable_reg_r[0];
          rdata_nxt[dtc_pkg::IEN_T1] = irq_enable_reg_r[1];
          rdata_nxt[dtc_pkg::IEN_GLOBAL] = irq_enable_reg_r[2];
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 2; i++) begin
        cnt_lo_r[i] <= dtc_pkg::RST_BYTE;
        cnt_hi_r[i] <= dtc_pkg::RST_BYTE;
      end
      run_bit_r <= 2'h0;
      overflow_flag_r <= 2'h0;
      timer_mode_reg_r <= dtc_pkg::RST_BYTE;
      irq_enable_reg_r <= 3'h0;
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      irq_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        cnt_lo_r[i] <= cnt_lo_nxt[i];
        cnt_hi_r[i] <= cnt_hi_nxt[i];
      end
      run_bit_r <= run_bit_nxt;
      overflow_flag_r <= overflow_flag_nxt;
      timer_mode_reg_r <= timer_mode_reg_nxt;
      irq_enable_reg_r <= irq_enable_reg_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign o_avs_waitrequest = wait_r;
  assign o_avs_readdata = rdata_r;
  assign o_irq_t0 = irq_r[0];
  assign o_irq_t1 = irq_r[1];

  logic t0_wr;
  logic t1_wr;

  // True when a bus address names one of the two count bytes of a timer
  function automatic logic dtc_hits_count(input logic [4:0] a, input logic t);
    if (t) begin
      return (a == dtc_pkg::OFS_T1_LO) || (a == dtc_pkg::OFS_T1_HI);
    end
    return (a == dtc_pkg::OFS_T0_LO) || (a == dtc_pkg::OFS_T0_HI);
  endfunction

  assign t0_wr = wr_take && dtc_hits_count(i_avs_address, 1'h0);
  assign t1_wr = wr_take && dtc_hits_count(i_avs_address, 1'h1);

  chk_ovf_sets_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ovf_evt[0] |=> overflow_flag_r[0]) else $error("Overflow did not set flag");
  chk_cascade_carry: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (inc[0] && mode[0] == dtc_pkg::DTC_MODE_16BIT && cnt_lo_r[0] == 8'hFF && !wr_take)
    |=> cnt_hi_r[0] == $past(cnt_hi_r[0]) + 8'h01 && cnt_lo_r[0] == 8'h00)
    else $error("16-bit carry wrong");
  chk_prescale_carry: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (inc[0] && mode[0] == dtc_pkg::DTC_MODE_13BIT && cnt_lo_r[0][4:0] == 5'h1F && !wr_take)
    |=> cnt_hi_r[0] == $past(cnt_hi_r[0]) + 8'h01 && cnt_lo_r[0][4:0] == 5'h00)
    else $error("Prescaler carry wrong");
  chk_reload_value: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (inc[0] && mode[0] == dtc_pkg::DTC_MODE_RELOAD && cnt_lo_r[0] == 8'hFF && !wr_take)
    |=> cnt_lo_r[0] == $past(cnt_hi_r[0]) && $stable(cnt_hi_r[0]) && overflow_flag_r[0])
    else $error("Reload wrong");
  chk_t1_halt: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (mode[1] == dtc_pkg::DTC_MODE_SPLIT && !t1_wr) |=> $stable(cnt_lo_r[1]))
    else $error("Timer 1 moved while halted");
  chk_gate_block: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (gate_bit[0] && !gate_lvl[0]) |-> !inc[0]) else $error("Gated timer counted");
  chk_run_needed: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    inc[0] |-> run_bit_r[0] && (src_sel[0] || tick)) else $error("Count without run");
  chk_irq_enable: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ##1 o_irq_t1 == ($past(overflow_flag_r[1]) && $past(irq_enable_reg_r[1])
    && $past(irq_enable_reg_r[2]))) else $error("Interrupt gating wrong");
  chk_vector_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_vec_ack_t0 && !ovf_evt[0] && !wr_take) |=> !overflow_flag_r[0])
    else $error("Vector did not clear flag");
  chk_bus_answer: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (req && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("Bus answer timing wrong");
  // A count byte moves only by an increment or a bus write, never by the run bit
  chk_run_keeps_count: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (!inc[0] && !hi0_inc && !t0_wr) |=> $stable(cnt_lo_r[0]) && $stable(cnt_hi_r[0]))
    else $error("Timer 0 count moved while idle");
  chk_gate_block_t1: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (gate_bit[1] && !gate_lvl[1]) |-> !inc[1]) else $error("Gated timer 1 counted");
  chk_t1_rate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (inc[1] && !src_sel[1]) |-> tick) else $error("Timer 1 counted off the tick");
  chk_reload_t1: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (inc[1] && mode[1] == dtc_pkg::DTC_MODE_RELOAD && cnt_lo_r[1] == 8'hFF
    && !t1_wr && !split0) |=> cnt_lo_r[1] == $past(cnt_hi_r[1]) && overflow_flag_r[1])
    else $error("Timer 1 reload wrong");
  chk_split_high: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (hi0_inc && cnt_hi_r[0] == 8'hFF && !wr_take) |=> cnt_hi_r[0] == 8'h00 && overflow_flag_r[1])
    else $error("Split high byte overflow wrong");
  chk_halt_high: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (mode[1] == dtc_pkg::DTC_MODE_SPLIT && !t1_wr) |=> $stable(cnt_hi_r[1]))
    else $error("Timer 1 high byte moved while halted");
  chk_ctrl_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (wr_take && i_avs_address == dtc_pkg::OFS_CTRL) |=> run_bit_r == $past({
      i_avs_writedata[dtc_pkg::CTRL_RUN_T1], i_avs_writedata[dtc_pkg::CTRL_RUN_T0]}))
    else $error("Run bits not written");

  cov_reload: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ovf_evt[0] && mode[0] == dtc_pkg::DTC_MODE_RELOAD);
  cov_split_hi: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
    hi0_inc && cnt_hi_r[0] == 8'hFF);
  cov_irq: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) o_irq_t0);
  cov_cascade: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ovf_evt[0] && mode[0] == dtc_pkg::DTC_MODE_16BIT);
endmodule

// *** dtc_pin_src.sv ***
// Model of the external event source that drives the count pins
`timescale 1ns/1ps
module dtc_pin_src #(
  parameter int HOLD_CLKS = 12
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire logic [7:0] i_edges,
  output logic o_pin,
  output logic o_busy
);
  logic [7:0] left_r;
  logic [7:0] hold_r;

  assign o_busy = (left_r != 8'h00) || (hold_r != 8'h00);

  // Each level stands two peripheral cycles, so the sampler cannot miss it
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      left_r <= 8'h00;
      hold_r <= 8'h00;
      o_pin <= 1'h1;
    end else if (i_go && !o_busy) begin
      left_r <= i_edges;
    end else if (hold_r != 8'h00) begin
      hold_r <= hold_r - 8'h01;
    end else if (left_r != 8'h00) begin
      o_pin <= ~o_pin;
      hold_r <= 8'(HOLD_CLKS - 1);
      if (!o_pin) begin
        left_r <= left_r - 8'h01;
      end
    end
  end
endmodule

// *** testbench.sv ***
// Self-checking bench for the dual timer/counter pair
`timescale 1ns/1ps
module testbench;
  localparam logic [4:0] CTL = dtc_pkg::OFS_CTRL;
  localparam logic [4:0] MOD = dtc_pkg::OFS_MODE;
  localparam logic [4:0] L0 = dtc_pkg::OFS_T0_LO;
  localparam logic [4:0] H0 = dtc_pkg::OFS_T0_HI;
  localparam logic [4:0] L1 = dtc_pkg::OFS_T1_LO;
  localparam logic [4:0] H1 = dtc_pkg::OFS_T1_HI;
  localparam logic [4:0] IEN = dtc_pkg::OFS_IRQ_EN;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [4:0] addr = 5'h00;
  logic rd_en = 1'h0;
  logic wr_en = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic gate_a = 1'h0;
  logic gate_b = 1'h0;
  logic ack0 = 1'h0;
  logic ack1 = 1'h0;
  logic go = 1'h0;
  logic [7:0] n_edges = 8'h00;
  logic [31:0] rdata;
  logic wait_req;
  logic pin;
  logic busy;
  logic irq0;
  logic irq1;
  logic [31:0] exp_q[$];
  logic [4:0] regs[8] = '{CTL, MOD, L0, H0, L1, H1, IEN, 5'h1C};
  int n_errors = 0;
  int samples_checked = 0;
  int k;
  int n;

  always #50 clk = ~clk;

  dtc_timer_pair dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr),
    .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
    .i_count_pin_t0(pin), .i_count_pin_t1(pin), .i_ext_gate_pin_a(gate_a),
    .i_ext_gate_pin_b(gate_b), .i_vec_ack_t0(ack0), .i_vec_ack_t1(ack1),
    .o_irq_t0(irq0), .o_irq_t1(irq1));

  dtc_pin_src src_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_edges(n_edges),
    .o_pin(pin), .o_busy(busy));

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic conclude();
    if (exp_q.size() != 0) begin
      n_errors++;
    end
    $display("errors %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] b);
    int t;
    @(posedge clk);
    addr <= a;
    wdata <= {24'h0, d};
    be <= b;
    wr_en <= w;
    rd_en <= ~w;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (wait_req !== 1'h0 && t < 50);
    if (t >= 50) begin
      n_errors++;
      $display("CHECK FAILED at %0t: bus access not answered", $time);
    end
    wr_en <= 1'h0;
    rd_en <= 1'h0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'h1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'h0, a, 8'h00, 4'hF);
  endtask

  // Run window of exactly 6*kk edges, so tick phase cannot change the count
  task automatic tmr(input logic [7:0] run, input int kk, input logic [7:0] mid);
    wr(CTL, run);
    repeat (6 * kk - 8) @(posedge clk);
    rd(CTL, mid);
    chk({30'h0, irq1, irq0}, {30'h0, mid[7], mid[5]});
    repeat (2) @(posedge clk);
    wr(CTL, 8'h00);
  endtask

  always @(posedge clk) begin
    if (rd_en === 1'h1 && wait_req === 1'h0) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("CHECK FAILED at %0t: read data with nothing expected", $time);
      end else begin
        chk(rdata, exp_q.pop_front());
      end
    end
  end

  initial begin
    #4000000;
    n_errors++;
    conclude();
  end

  initial begin
    void'($urandom(32'hBE526EEF));
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    wr(CTL, 8'h0F);
    rd(CTL, 8'h00);
    wr(MOD, 8'hA5);
    rd(MOD, 8'hA5);
    bus(1'h1, L0, 8'h33, 4'hE);
    rd(L0, 8'h00);
    wr(5'h1C, 8'hFF);
    rd(5'h1C, 8'h00);
    wr(IEN, 8'h83);
    wr(MOD, 8'h01);
    wr(L0, 8'hFF);
    wr(H0, 8'hFF);
    tmr(8'h10, 3, 8'h30);
    rd(L0, 8'h02);
    rd(H0, 8'h00);
    wr(MOD, 8'h00);
    wr(L0, 8'h1E);
    wr(H0, 8'hFF);
    tmr(8'h10, 4, 8'h30);
    rd(L0, 8'h02);
    rd(H0, 8'h00);
    wr(MOD, 8'h22);
    wr(L0, 8'hFF);
    wr(H0, 8'h40);
    wr(L1, 8'hFF);
    wr(H1, 8'h80);
    tmr(8'h50, 3, 8'hF0);
    rd(L0, 8'h42);
    rd(H0, 8'h40);
    rd(L1, 8'h82);
    rd(H1, 8'h80);
    wr(MOD, 8'h33);
    wr(L0, 8'hFF);
    wr(H0, 8'hFF);
    wr(L1, 8'h55);
    wr(H1, 8'h66);
    tmr(8'h50, 3, 8'hF0);
    rd(L0, 8'h02);
    rd(H0, 8'h02);
    rd(L1, 8'h55);
    rd(H1, 8'h66);
    wr(MOD, 8'h10);
    wr(L1, 8'h00);
    wr(H1, 8'h00);
    k = $urandom_range(3, 40);
    tmr(8'h40, k, 8'h40);
    rd(L1, 8'(k));
    n = $urandom_range(3, 20);
    wr(MOD, 8'h55);
    wr(L0, 8'h00);
    wr(L1, 8'h00);
    wr(CTL, 8'h50);
    n_edges <= 8'(n);
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 2000 && busy === 1'h1; i++) @(posedge clk);
    chk({31'h0, busy}, 32'h0);
    repeat (30) @(posedge clk);
    wr(CTL, 8'h00);
    rd(L0, 8'(n));
    rd(L1, 8'(n));
    gate_a <= 1'h1;
    wr(MOD, 8'h99);
    wr(L0, 8'h00);
    wr(L1, 8'h00);
    tmr(8'h50, 5, 8'h50);
    rd(L0, 8'h05);
    rd(L1, 8'h00);
    gate_a <= 1'h0;
    gate_b <= 1'h1;
    tmr(8'h50, 5, 8'h50);
    rd(L0, 8'h05);
    rd(L1, 8'h05);
    wr(CTL, 8'hA0);
    repeat (3) @(posedge clk);
    chk({30'h0, irq1, irq0}, 32'h3);
    wr(IEN, 8'h03);
    repeat (3) @(posedge clk);
    chk({30'h0, irq1, irq0}, 32'h0);
    wr(IEN, 8'h81);
    ack0 <= 1'h1;
    @(posedge clk);
    ack0 <= 1'h0;
    repeat (3) @(posedge clk);
    chk({30'h0, irq1, irq0}, 32'h0);
    rd(CTL, 8'h80);
    ack1 <= 1'h1;
    @(posedge clk);
    ack1 <= 1'h0;
    repeat (3) @(posedge clk);
    rd(CTL, 8'h00);
    repeat (3) @(posedge clk);
    conclude();
  end
endmodule
